// *** fspc_params.svh ***
// constants for the flash sector protection host controller
// assumes a 10 MHz system clock and a 21-bit word address on the flash
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH
`define FSPC_NUM_GROUPS     25
`define FSPC_REG_CMD        4'h0
`define FSPC_REG_ADDR       4'h1
`define FSPC_REG_DATA       4'h2
`define FSPC_REG_STATUS     4'h3
`define FSPC_REG_RDATA      4'h4
`define FSPC_REG_CFG        4'h5
`define FSPC_UNLOCK1_ADDR   21'h000555
`define FSPC_UNLOCK2_ADDR   21'h0002AA
`define FSPC_UNLOCK1_DATA   16'h00AA
`define FSPC_UNLOCK2_DATA   16'h0055
`define FSPC_PROG_DATA      16'h00A0
`define FSPC_ERASE_DATA     16'h0080
`define FSPC_SECT_ERASE     16'h0030
`define FSPC_AUTOSEL_DATA   16'h0090
`define FSPC_SEC_ENTER      16'h0088
`define FSPC_SEC_EXIT       16'h0000
`define FSPC_RESET_DATA     16'h00F0
`define FSPC_CYC_NS         100
`define FSPC_PHASE_NS       100
`define FSPC_PHASE_CYC      ((`FSPC_PHASE_NS + `FSPC_CYC_NS - 1) / `FSPC_CYC_NS)
`define FSPC_ID_BOT_LO      21'h000000
`define FSPC_ID_TOP_LO      21'h1F8000
`define FSPC_ID_WORDS       8
`define FSPC_LOCK_BIT       7
`define FSPC_STAT_BUSY      0
`define FSPC_STAT_REFUSED   1
`define FSPC_STAT_SECURE    2
`define FSPC_STAT_LOCKIND   3
`define FSPC_STAT_LOWVCC    4
`define FSPC_CFG_TOPBOOT    0
`define FSPC_CFG_BOOTLOCK   1
`define FSPC_CFG_ELEVATED   2
`endif

// *** fspc_pkg.sv ***
// types for the flash sector protection host controller
// assumes fspc_params.svh holds the numeric constants
package fspc_pkg;
	// software commands written to the command register
	typedef enum logic [3:0] {
		FSPC_OP_NONE, FSPC_OP_PROG, FSPC_OP_SECT_ERASE, FSPC_OP_AUTOSEL,
		FSPC_OP_SEC_ENTER, FSPC_OP_SEC_EXIT, FSPC_OP_READ, FSPC_OP_RESET
	} fspc_op_t;
	typedef enum logic [2:0] {
		FSPC_IDLE, FSPC_SETUP, FSPC_STROBE, FSPC_HOLD, FSPC_NEXT
	} fspc_state_t;
endpackage

// *** fspc_host.sv ***
// host controller that drives the flash bus cycles for protection work
// assumes flash pins are asynchronous and software uses the plain register port
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_host
	import fspc_pkg::*;
(
	input  wire logic        i_clk_sys,     // 10 MHz clock
	input  wire logic        i_reset,       // sync reset, high
	input  wire logic        i_ce,          // clock enable
	input  wire logic [3:0]  i_addr,        // register index
	input  wire logic [31:0] i_wdata,       // register write data
	input  wire logic        i_wr,          // write strobe
	input  wire logic        i_rd,          // read strobe
	output logic      [31:0] o_rdata,       // read data, next cycle
	input  wire logic        i_low_supply,  // supply below lockout, from pin
	output logic      [20:0] o_fl_addr,     // flash word address
	output logic      [15:0] o_fl_dq_o,     // flash data out
	output logic             o_fl_dq_oe,    // flash data drive enable
	input  wire logic [15:0] i_fl_dq_i,     // flash data in
	output logic             o_fl_ce_n,     // flash chip enable, low
	output logic             o_fl_we_n,     // flash write enable, low
	output logic             o_fl_oe_n,     // flash output enable, low
	output logic             o_boot_lock_pin,          // boot-lock pin level
	output logic             o_elevated_unprotect_level // raise reset pin to high level
);
	typedef struct packed {
		fspc_state_t st;
		logic [2:0]  idx;       // cycle within the sequence
		logic [2:0]  len;       // cycles in the sequence
		logic [3:0]  op;
		logic        is_read;
		logic [20:0] addr;
		logic [15:0] data;
		logic [20:0] fa;
		logic [15:0] fd;
		logic        ce_n, we_n, oe_n, dq_oe;
		logic [15:0] rdat;
		logic        secure, refused, top, lockb, elev, lockind;
		logic [2:0]  lv;        // supply lockout synchroniser
		logic        low;       // filtered lockout level
		logic [31:0] rdata;
	} fspc_regs_t;
	fspc_regs_t r, next_r;

	// one bus cycle of a command sequence: address and data by position
	function automatic logic [36:0] seq_cycle(input logic [3:0] op, input logic [2:0] i,
		input logic [20:0] a, input logic [15:0] d);
		logic [20:0] ca;
		logic [15:0] cd;
		logic        odd;
		// unlock pairs restart at cycle three, as the six-cycle erase needs
		odd = i[0] ^ (i >= 3'd3);
		ca = odd ? `FSPC_UNLOCK2_ADDR : `FSPC_UNLOCK1_ADDR;
		cd = odd ? `FSPC_UNLOCK2_DATA : `FSPC_UNLOCK1_DATA;
		case (op)
		FSPC_OP_PROG: if (i == 3'd2) cd = `FSPC_PROG_DATA;
			else if (i == 3'd3) begin ca = a; cd = d; end
		FSPC_OP_SECT_ERASE: if (i == 3'd2) cd = `FSPC_ERASE_DATA;
			else if (i == 3'd5) begin ca = a; cd = `FSPC_SECT_ERASE; end
		FSPC_OP_AUTOSEL: if (i == 3'd2) cd = `FSPC_AUTOSEL_DATA;
			else if (i == 3'd3) ca = a;
		FSPC_OP_SEC_ENTER: if (i == 3'd2) cd = `FSPC_SEC_ENTER;
		FSPC_OP_SEC_EXIT: if (i == 3'd2) cd = `FSPC_AUTOSEL_DATA;
			else if (i == 3'd3) cd = `FSPC_SEC_EXIT;
		FSPC_OP_READ: ca = a;
		default: begin ca = a; cd = `FSPC_RESET_DATA; end
		endcase
		return {ca, cd};
	endfunction

	// number of bus cycles per command
	function automatic logic [2:0] seq_len(input logic [3:0] op);
		case (op)
		FSPC_OP_PROG:       seq_len = 3'd4;
		FSPC_OP_SECT_ERASE: seq_len = 3'd6;
		FSPC_OP_AUTOSEL:    seq_len = 3'd4;
		FSPC_OP_SEC_ENTER:  seq_len = 3'd3;
		FSPC_OP_SEC_EXIT:   seq_len = 3'd4;
		default:            seq_len = 3'd1;
		endcase
	endfunction

	logic        lowvcc;
	logic        busy;
	logic [36:0] cyc;
	logic        target_first;
	assign lowvcc = r.low;
	assign busy   = (r.st != FSPC_IDLE);
	assign cyc    = seq_cycle(r.op, r.idx, r.addr, r.data);
	// first-sector addresses, which reach the secure region when entered
	assign target_first = r.top ? (r.addr[20:15] == 6'h3F) : (r.addr[20:15] == 6'h00);

	always_comb begin
		next_r = r;
		next_r.lv = {r.lv[1:0], i_low_supply};
		// lockout follows the pin only once the late flops agree, filtering glitches
		if (r.lv[2] == r.lv[1]) next_r.low = r.lv[2];
		// read data stand in the cycle after the strobe only
		next_r.rdata = 32'h0000_0000;
		if (i_rd) begin
			if (i_addr == `FSPC_REG_ADDR) next_r.rdata = {11'h000, r.addr};
			else if (i_addr == `FSPC_REG_DATA) next_r.rdata = {16'h0000, r.data};
			else if (i_addr == `FSPC_REG_RDATA) next_r.rdata = {16'h0000, r.rdat};
			else if (i_addr == `FSPC_REG_CFG)
				next_r.rdata = {29'h0, r.elev, r.lockb, r.top};
			// secure flag lets software exit before array access
			else if (i_addr == `FSPC_REG_STATUS)
				next_r.rdata = {27'h0, lowvcc, r.lockind, r.secure, r.refused, busy};
		end
		if (i_wr) begin
			if (i_addr == `FSPC_REG_ADDR) next_r.addr = i_wdata[20:0];
			else if (i_addr == `FSPC_REG_DATA) next_r.data = i_wdata[15:0];
			else if (i_addr == `FSPC_REG_CFG) begin
				next_r.top   = i_wdata[`FSPC_CFG_TOPBOOT];
				next_r.lockb = i_wdata[`FSPC_CFG_BOOTLOCK];
				next_r.elev  = i_wdata[`FSPC_CFG_ELEVATED];
			end
		end
		case (r.st)
		FSPC_IDLE: begin
			if (i_wr && i_addr == `FSPC_REG_CMD) begin
				next_r.op      = i_wdata[3:0];
				next_r.len     = seq_len(i_wdata[3:0]);
				next_r.idx     = 3'd0;
				next_r.is_read = (i_wdata[3:0] == FSPC_OP_READ) ||
				                 (i_wdata[3:0] == FSPC_OP_AUTOSEL);
				next_r.refused = 1'b0;
				if (lowvcc && i_wdata[3:0] != FSPC_OP_READ)
					next_r.refused = 1'b1;
				else if (r.secure && r.lockind && target_first &&
				         (i_wdata[3:0] == FSPC_OP_PROG || i_wdata[3:0] == FSPC_OP_SECT_ERASE))
					next_r.refused = 1'b1;
				else if (i_wdata[3:0] != FSPC_OP_NONE)
					next_r.st = FSPC_SETUP;
			end
		end
		FSPC_SETUP: begin
			next_r.fa = cyc[36:16];
			next_r.fd = cyc[15:0];
			next_r.ce_n = 1'b0;
			next_r.dq_oe = !(r.is_read && r.idx == r.len - 3'd1);
			next_r.st = FSPC_STROBE;
		end
		FSPC_STROBE: begin
			if (r.dq_oe) next_r.we_n = 1'b0;
			else next_r.oe_n = 1'b0;
			next_r.st = FSPC_HOLD;
		end
		FSPC_HOLD: begin
			if (!r.dq_oe) next_r.rdat = i_fl_dq_i;
			next_r.we_n = 1'b1;
			next_r.oe_n = 1'b1;
			next_r.st = FSPC_NEXT;
		end
		default: begin
			next_r.ce_n = 1'b1;
			next_r.dq_oe = 1'b0;
			if (r.idx == r.len - 3'd1) begin
				next_r.st = FSPC_IDLE;
				// secure mapping follows enter and exit
				if (r.op == FSPC_OP_SEC_ENTER) next_r.secure = 1'b1;
				// the reset command leaves secure mapping alone; only exit or i_reset ends it
				if (r.op == FSPC_OP_SEC_EXIT) next_r.secure = 1'b0;
				// lock indicator on bit 7 when autoselect read in secure mapping
				if (r.op == FSPC_OP_AUTOSEL && r.secure)
					next_r.lockind = next_r.rdat[`FSPC_LOCK_BIT];
			end else begin
				next_r.idx = r.idx + 3'd1;
				next_r.st = FSPC_SETUP;
			end
		end
		endcase
	end

	// single register bank; clock enable freezes everything, but i_reset still loads it
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			r <= '0;
			r.ce_n <= 1'b1;
			r.we_n <= 1'b1;
			r.oe_n <= 1'b1;
			r.lockb <= 1'b1;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_rdata    = r.rdata;
	assign o_fl_addr  = r.fa;
	assign o_fl_dq_o  = r.fd;
	assign o_fl_dq_oe = r.dq_oe;
	assign o_fl_ce_n  = r.ce_n;
	assign o_fl_we_n  = r.we_n;
	assign o_fl_oe_n  = r.oe_n;
	assign o_boot_lock_pin = r.lockb;
	// software protects every open group before its first unprotect cycle
	assign o_elevated_unprotect_level = r.elev;

	// never write and read the flash at once
	strobes_excl_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!(!o_fl_we_n && !o_fl_oe_n)) else $error("we and oe low together");
	// a write strobe falls only while chip enable is low and data driven
	we_with_ce_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		$fell(o_fl_we_n) |-> !o_fl_ce_n && o_fl_dq_oe) else $error("we without ce");
	// low supply refuses a program command
	lowvcc_refuse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_ce && lowvcc && i_wr && i_addr == `FSPC_REG_CMD && i_wdata[3:0] == FSPC_OP_PROG
		 && !busy) |=> r.refused && !busy) else $error("write under lockout");
	// reset clears secure mapping
	secure_reset_a: assert property (@(posedge i_clk_sys)
		i_reset |=> !r.secure) else $error("secure after reset");
	// a program into a factory-locked secure region starts no bus cycle
	secure_refuse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_ce && r.secure && r.lockind && target_first && i_wr && i_addr == `FSPC_REG_CMD
		 && i_wdata[3:0] == FSPC_OP_PROG && !busy) |=> r.refused && !busy)
		else $error("program into locked secure region");
endmodule

// *** fspc_flash_model.sv ***
// behavioural flash array: group protection, secure region, supply lockout
// assumes the bottom-boot layout and strobes driven by the host
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_flash_model (
	input  wire logic [20:0] i_a,    // word address
	input  wire logic [15:0] i_d,    // data from host
	output logic      [15:0] o_q,    // data to host
	input  wire logic        i_ce_n, // chip enable, low
	input  wire logic        i_we_n, // write enable, low
	input  wire logic        i_oe_n, // output enable, low
	input  wire logic        i_wp,   // boot-lock pin
	input  wire logic        i_hv,   // elevated reset level
	input  wire logic        i_low   // supply below lockout
);
	localparam logic [36:0] U1 = {`FSPC_UNLOCK1_ADDR, `FSPC_UNLOCK1_DATA};
	localparam logic [36:0] U2 = {`FSPC_UNLOCK2_ADDR, `FSPC_UNLOCK2_DATA};
	logic [15:0] mem[logic [20:0]];
	logic [15:0] sec[logic [20:0]];
	logic [36:0] h[$];
	logic [15:0] last = 16'h0000;
	// one flag per group, all clear
	bit prot[25];
	// fixed indicator, 0 = customer lockable
	bit lock_ind = 0;
	// powers up mapped to the boot sectors
	bit secure = 0;
	bit asel = 0;
	int n;
	// serial id words preset at the bottom of the secure region; values arbitrary
	initial begin
		for (int i = 0; i < `FSPC_ID_WORDS; i++) sec[`FSPC_ID_BOT_LO + 21'(i)] = 16'hA5A0 + 16'(i);
	end
	function automatic int grp(logic [20:0] a);
		if (a[20:15] == 6'h00) return 24 - int'(a[14:12]);
		if (a[20:17] == 4'h0) return 16;
		if (a[20:15] == 6'h3F) return 0;
		if (a[20:17] == 4'hF) return 1;
		return 16 - int'(a[20:17]);
	endfunction
	// first-sector addresses reach the secure region
	function automatic bit in_sec(logic [20:0] a);
		return secure && a[20:15] == 6'h00;
	endfunction
	function automatic bit blk(logic [20:0] a);
		if (in_sec(a)) return lock_ind;
		if (!i_wp && grp(a) >= 23) return 1;
		return prot[grp(a)] && !i_hv;
	endfunction
	// commands other than reset only after unlock cycles, none under lockout
	always @(posedge i_we_n) if (i_ce_n === 1'b0 && !i_low) begin
		h.push_back({i_a, i_d});
		if (h.size() > 6) void'(h.pop_front());
		n = h.size();
		if (i_d == `FSPC_RESET_DATA) begin
			asel = 0;
			h = {};
		end else if (n >= 3 && h[n-3] == U1 && h[n-2] == U2) begin
			// entering is the first step of locking
			if (i_d == `FSPC_SEC_ENTER) secure = 1;
			if (i_d == `FSPC_AUTOSEL_DATA) asel = 1;
		end else if (n >= 4 && h[n-4] == U1 && h[n-3] == U2) begin
			if (h[n-2][15:0] == `FSPC_PROG_DATA && !blk(i_a)) begin
				if (in_sec(i_a)) sec[i_a] = i_d;
				else mem[i_a] = i_d;
			end
			if (h[n-2][15:0] == `FSPC_AUTOSEL_DATA && i_d == `FSPC_SEC_EXIT) begin
				secure = 0;
				asel = 0;
			end
		end
		if (n == 6 && h[0] == U1 && h[4] == U2 && i_d == `FSPC_SECT_ERASE && !blk(i_a))
			foreach (mem[k]) if (grp(k) == grp(i_a)) mem[k] = 16'hFFFF;
	end
	// status read at an address inside the group; released bus inverts
	always @* begin
		if (!i_ce_n && !i_oe_n) begin
			if (asel) o_q = {8'h00, lock_ind & secure, 6'h00, prot[grp(i_a)]};
			else if (in_sec(i_a)) o_q = sec.exists(i_a) ? sec[i_a] : 16'hFFFF;
			else o_q = mem.exists(i_a) ? mem[i_a] : 16'hFFFF;
			last = o_q;
		end else o_q = ~last;
	end
endmodule

// *** tb_top.sv ***
// self-checking bench: host controller against the flash model
// assumes the register map and op codes of the controller package
`timescale 1ns/1ps
`include "fspc_params.svh"
module tb_top;
	import fspc_pkg::*;
	logic        clk_sys = 0, i_reset = 1, i_ce = 1, i_wr = 0, i_rd = 0, low = 0;
	logic [3:0]  i_addr = 0;
	logic [31:0] i_wdata = 0, o_rdata;
	logic [20:0] fa;
	logic [15:0] dq_o, dq_i;
	logic        dq_oe, ce_n, we_n, oe_n, wp, hv;
	int n_mismatch = 0, num_checks = 0, seed = 14130, ref_mem[int];
	bit sec_on = 0;
	logic [31:0] v;
	always #50 clk_sys = ~clk_sys;
	fspc_host fspc_host_i (.i_clk_sys(clk_sys), .i_reset(i_reset), .i_ce(i_ce),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_low_supply(low), .o_fl_addr(fa), .o_fl_dq_o(dq_o), .o_fl_dq_oe(dq_oe),
		.i_fl_dq_i(dq_i), .o_fl_ce_n(ce_n), .o_fl_we_n(we_n), .o_fl_oe_n(oe_n),
		.o_boot_lock_pin(wp), .o_elevated_unprotect_level(hv));
	fspc_flash_model fspc_flash_model_i (.i_a(fa), .i_d(dq_o), .o_q(dq_i), .i_ce_n(ce_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_wp(wp), .i_hv(hv), .i_low(low));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one idle cycle after each strobe keeps drivers single-assigned
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		i_addr <= a; i_wdata <= d; i_wr <= 1'b1; @(posedge clk_sys);
		i_wr <= 1'b0; @(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		i_addr <= a; i_rd <= 1'b1; @(posedge clk_sys);
		i_rd <= 1'b0; #1 d = o_rdata; @(posedge clk_sys);
	endtask
	task automatic cmd(input fspc_op_t op, input logic [20:0] a, input logic [15:0] d);
		logic [31:0] s; int k;
		wr(`FSPC_REG_ADDR, {11'h000, a}); wr(`FSPC_REG_DATA, {16'h0000, d});
		wr(`FSPC_REG_CMD, {28'h0000000, op});
		s = 32'h1; k = 0;
		while (s[0] !== 1'b0 && k < 100) begin rd(`FSPC_REG_STATUS, s); k++; end
		if (k == 100) chk(32'h1, 32'h0);
	endtask
	// reads the word back and compares with the bench's reference image
	task automatic rchk(input logic [20:0] a);
		int key;
		key = (sec_on && a[20:15] == 6'h00) ? int'(a) + 32'h400000 : int'(a);
		cmd(FSPC_OP_READ, a, 16'h0000); rd(`FSPC_REG_RDATA, v);
		chk(v, ref_mem.exists(key) ? 32'(ref_mem[key]) : 32'h0000FFFF);
	endtask
	task automatic pc(input logic [20:0] a, input bit ok);
		logic [15:0] d;
		d = 16'($random(seed));
		cmd(FSPC_OP_PROG, a, d);
		if (ok) ref_mem[(sec_on && a[20:15] == 6'h00) ? int'(a) + 32'h400000 : int'(a)] = d;
		rchk(a);
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(20000 * 100);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		// serial id words as preset in the secure region of the model
		for (int i = 0; i < `FSPC_ID_WORDS; i++) ref_mem[32'h400000 + i] = 32'hA5A0 + i;
		repeat (2) @(posedge clk_sys);
		i_reset <= 1'b0;
		@(posedge clk_sys);
		rd(`FSPC_REG_STATUS, v); chk(v & 32'h7, 32'h0);
		repeat (4) pc(21'($random(seed)) | 21'h008000, 1);
		fspc_flash_model_i.prot[2] = 1;
		pc(21'h1C0010, 0);
		wr(`FSPC_REG_CFG, 32'h6); pc(21'h1C0020, 1);
		wr(`FSPC_REG_CFG, 32'h2); pc(21'h1C0030, 0);
		fspc_flash_model_i.prot[2] = 0;
		pc(21'h1C0040, 1);
		cmd(FSPC_OP_SECT_ERASE, 21'h1C0000, 16'h0000);
		ref_mem[32'h1C0020] = 16'hFFFF; ref_mem[32'h1C0040] = 16'hFFFF;
		rchk(21'h1C0020);
		wr(`FSPC_REG_CFG, 32'h0); pc(21'h000100, 0);
		pc(21'h002100, 1);
		wr(`FSPC_REG_CFG, 32'h4); pc(21'h001100, 0);
		wr(`FSPC_REG_CFG, 32'h2); pc(21'h001200, 1);
		// a write while the clock enable is low must leave the config untouched
		i_ce <= 1'b0; wr(`FSPC_REG_CFG, 32'h0); i_ce <= 1'b1;
		rd(`FSPC_REG_CFG, v); chk(v, 32'h2);
		cmd(FSPC_OP_SEC_ENTER, 21'h000000, 16'h0000); sec_on = 1;
		pc(21'h000010, 1);
		rchk(21'h000003);
		cmd(FSPC_OP_SEC_EXIT, 21'h000000, 16'h0000); sec_on = 0;
		rchk(21'h000010);
		fspc_flash_model_i.lock_ind = 1;
		cmd(FSPC_OP_SEC_ENTER, 21'h000000, 16'h0000);
		cmd(FSPC_OP_AUTOSEL, 21'h000000, 16'h0000);
		rd(`FSPC_REG_STATUS, v); chk(32'(v[3]), 32'h1);
		cmd(FSPC_OP_RESET, 21'h000000, 16'h00F0);
		cmd(FSPC_OP_PROG, 21'h000020, 16'h1234);
		rd(`FSPC_REG_STATUS, v); chk(32'(v[1]), 32'h1);
		// top-boot layout moves the secure region to the high end
		wr(`FSPC_REG_CFG, 32'h3); cmd(FSPC_OP_PROG, 21'h1F8004, 16'h1234);
		rd(`FSPC_REG_STATUS, v); chk(32'(v[1]), 32'h1);
		cmd(FSPC_OP_PROG, 21'h000020, 16'h1234);
		rd(`FSPC_REG_STATUS, v); chk(32'(v[1]), 32'h0);
		wr(`FSPC_REG_CFG, 32'h2);
		cmd(FSPC_OP_SEC_EXIT, 21'h000000, 16'h0000);
		low <= 1'b1; repeat (4) @(posedge clk_sys);
		cmd(FSPC_OP_PROG, 21'h0A0000, 16'h5A5A);
		rd(`FSPC_REG_STATUS, v); chk(v & 32'h12, 32'h12);
		rd(4'hF, v);
		report_and_stop;
	end
endmodule
